// ===== lcgim_matrix.sv
// logic cell gate input matrix: source muxes, per-gate enable OR, polarity, AXI4-Lite registers
// assumes candidate signals and AXI inputs are synchronous to clk; one write and one read at a time
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`default_nettype none
module lcgim_matrix
    import lcgim_pkg::*;
(
    input  wire logic        clk,            // 20 MHz clock
    input  wire logic        rst,            // synchronous reset, active high
    input  wire logic [7:0]  source1_cands,  // eight candidates for source 1
    input  wire logic [7:0]  source2_cands,  // eight candidates for source 2
    input  wire logic [7:0]  source3_cands,  // eight candidates for source 3
    input  wire logic [7:0]  source4_cands,  // eight candidates for source 4
    output logic [3:0]       gate_out,       // registered gate outputs to the logic cell
    input  wire logic [3:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write byte strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [3:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready    // read data ready
);

    logic [15:0]   gate_select_low_r;
    logic [15:0]   gate_select_high_r;
    logic [3:0]    gate_polarity_r;
    logic [15:0]   source_select_r;
    logic [3:0]    source_data;
    logic [3:0]    gate_raw;
    lcgim_status_t status;

    // byte-strobed update of a 16-bit register
    function automatic logic [15:0] lcgim_merge(input logic [15:0] old_v, input logic [31:0] d,
                                                input logic [3:0] strb);
        logic [15:0] v;
        v = old_v;
        if (strb[0]) begin
            v[7:0] = d[7:0];
        end
        if (strb[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction : lcgim_merge

    // OR of the enabled true and inverted terms of one gate
    function automatic logic lcgim_gate(input lcgim_gate_en_t en, input logic [3:0] d);
        logic g;
        g = 1'b0;
        g = g | (en.s1_true & d[0]) | (en.s1_inv & ~d[0]);
        g = g | (en.s2_true & d[1]) | (en.s2_inv & ~d[1]);
        g = g | (en.s3_true & d[2]) | (en.s3_inv & ~d[2]);
        g = g | (en.s4_true & d[3]) | (en.s4_inv & ~d[3]);
        return g;
    endfunction : lcgim_gate

    function automatic logic lcgim_decode_ok(input logic [3:0] a);
        return (a == LCGIM_OFF_SEL_LOW) || (a == LCGIM_OFF_SEL_HIGH) ||
               (a == LCGIM_OFF_POLARITY) || (a == LCGIM_OFF_SOURCE);
    endfunction : lcgim_decode_ok

    // source multiplexers
    always_comb begin
        source_data[0] = source1_cands[source_select_r[2:0]];
        source_data[1] = source2_cands[source_select_r[6:4]];
        source_data[2] = source3_cands[source_select_r[10:8]];
        source_data[3] = source4_cands[source_select_r[14:12]];
    end

    // gate byte placement
    always_comb begin
        gate_raw[0] = lcgim_gate(lcgim_gate_en_t'(gate_select_low_r[7:0]), source_data);
        gate_raw[1] = lcgim_gate(lcgim_gate_en_t'(gate_select_low_r[15:8]), source_data);
        gate_raw[2] = lcgim_gate(lcgim_gate_en_t'(gate_select_high_r[7:0]), source_data);
        gate_raw[3] = lcgim_gate(lcgim_gate_en_t'(gate_select_high_r[15:8]), source_data);
    end

    // registered so the cell sees glitch-free levels; costs one cycle of latency
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_out <= 4'h0;
        end else begin
            gate_out <= gate_raw ^ gate_polarity_r;
        end
    end

    // one driver for the whole struct; per-member continuous drives upset some front ends
    assign status = lcgim_status_t'({gate_out, gate_raw, source_data});

    // write channel: address and data accepted together or in either order
    lcgim_wstate_t wstate_r;
    logic          aw_held_r;
    logic          w_held_r;
    logic [3:0]    awaddr_r;
    logic [31:0]   wdata_r;
    logic [3:0]    wstrb_r;
    logic          aw_now;
    logic          w_now;
    logic          do_write;
    logic [3:0]    wa;
    logic [31:0]   wd;
    logic [3:0]    ws;

    assign s_axi_awready = (wstate_r == LCGIM_W_IDLE) && !aw_held_r;
    assign s_axi_wready  = (wstate_r == LCGIM_W_IDLE) && !w_held_r;
    assign aw_now        = s_axi_awvalid && s_axi_awready;
    assign w_now         = s_axi_wvalid && s_axi_wready;
    assign do_write      = (wstate_r == LCGIM_W_IDLE) && (aw_now || aw_held_r) && (w_now || w_held_r);
    assign wa            = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wd            = w_held_r ? wdata_r : s_axi_wdata;
    assign ws            = w_held_r ? wstrb_r : s_axi_wstrb;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 4'h0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
        end else begin
            if (aw_now) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_now) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wstate_r    <= LCGIM_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= LCGIM_RESP_OKAY;
        end else begin
            case (wstate_r)
                LCGIM_W_IDLE: begin
                    if (do_write) begin
                        wstate_r     <= LCGIM_W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= lcgim_decode_ok(wa) ? LCGIM_RESP_OKAY : LCGIM_RESP_SLVERR;
                    end
                end
                LCGIM_W_RESP: begin
                    if (s_axi_bready) begin
                        wstate_r     <= LCGIM_W_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wstate_r     <= LCGIM_W_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_select_low_r  <= LCGIM_RST_SEL_LOW;
            gate_select_high_r <= LCGIM_RST_SEL_HIGH;
            gate_polarity_r    <= LCGIM_RST_POLARITY;
            source_select_r    <= LCGIM_RST_SOURCE;
        end else if (do_write) begin
            case (wa)
                LCGIM_OFF_SEL_LOW:  gate_select_low_r  <= lcgim_merge(gate_select_low_r, wd, ws);
                LCGIM_OFF_SEL_HIGH: gate_select_high_r <= lcgim_merge(gate_select_high_r, wd, ws);
                LCGIM_OFF_POLARITY: begin
                    if (ws[0]) begin
                        gate_polarity_r <= wd[3:0];
                    end
                end
                LCGIM_OFF_SOURCE:   source_select_r <= lcgim_merge(source_select_r, wd, ws) & LCGIM_SOURCE_MASK;
                default: ;
            endcase
        end
    end

    // read channel: one cycle to answer, holds until rready
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= LCGIM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= LCGIM_RESP_OKAY;
            case (s_axi_araddr)
                LCGIM_OFF_SEL_LOW:  s_axi_rdata <= {16'h0000, gate_select_low_r};
                LCGIM_OFF_SEL_HIGH: s_axi_rdata <= {16'h0000, gate_select_high_r};
                LCGIM_OFF_POLARITY: s_axi_rdata <= {16'h0000, status, gate_polarity_r};
                LCGIM_OFF_SOURCE:   s_axi_rdata <= {16'h0000, source_select_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= LCGIM_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    // the cycle before must be out of reset, else $past still sees unreset registers
    a_gate_polarity_out: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> (gate_out == ($past(gate_raw) ^ $past(gate_polarity_r))))
        else $error("gate output does not follow raw gate and polarity");

    a_gate1_none_zero: assert property (@(posedge clk) disable iff (rst)
        (gate_select_low_r[7:0] == 8'h00) |-> !gate_raw[0])
        else $error("gate 1 high with no terms enabled");

    a_gate1_true_s1: assert property (@(posedge clk) disable iff (rst)
        (gate_select_low_r[1] && source_data[0]) |-> gate_raw[0])
        else $error("gate 1 misses enabled true source 1");

    a_gate2_inv_s1: assert property (@(posedge clk) disable iff (rst)
        (gate_select_low_r[8] && !source_data[0]) |-> gate_raw[1])
        else $error("gate 2 misses enabled inverted source 1");

    a_gate2_true_s4: assert property (@(posedge clk) disable iff (rst)
        (gate_select_low_r[15:8] == 8'h80) |-> (gate_raw[1] == source_data[3]))
        else $error("gate 2 not equal to source 4");

    a_gate3_inv_s4: assert property (@(posedge clk) disable iff (rst)
        (gate_select_high_r[7:0] == 8'h40) |-> (gate_raw[2] == !source_data[3]))
        else $error("gate 3 not inverted source 4");

    a_gate4_true_s1: assert property (@(posedge clk) disable iff (rst)
        (gate_select_high_r[15:8] == 8'h02) |-> (gate_raw[3] == source_data[0]))
        else $error("gate 4 not equal to source 1");

    a_source4_mux_pick: assert property (@(posedge clk) disable iff (rst)
        source_data[3] == source4_cands[source_select_r[14:12]])
        else $error("source 4 mux picked the wrong candidate");

    sequence s_write_taken;
        do_write;
    endsequence
    a_write_resp_next: assert property (@(posedge clk) disable iff (rst)
        s_write_taken |=> s_axi_bvalid)
        else $error("write response missing one cycle after write");

endmodule : lcgim_matrix
`default_nettype wire

// ===== lcgim_pkg.sv
// package for the logic cell gate input matrix: register map, field layout, reset values
// assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses
`default_nettype none
package lcgim_pkg;
    localparam logic [3:0]  LCGIM_OFF_SEL_LOW   = 4'h0;   // gate_select_low
    localparam logic [3:0]  LCGIM_OFF_SEL_HIGH  = 4'h4;   // gate_select_high
    localparam logic [3:0]  LCGIM_OFF_POLARITY  = 4'h8;   // gate output invert bits
    localparam logic [3:0]  LCGIM_OFF_SOURCE    = 4'hC;   // four 3-bit source selects
    localparam logic [15:0] LCGIM_RST_SEL_LOW   = 16'h0000;
    localparam logic [15:0] LCGIM_RST_SEL_HIGH  = 16'h0000;
    localparam logic [3:0]  LCGIM_RST_POLARITY  = 4'h0;
    localparam logic [15:0] LCGIM_RST_SOURCE    = 16'h0000;
    localparam logic [15:0] LCGIM_SOURCE_MASK   = 16'h7777; // unimplemented bits read zero
    localparam int          LCGIM_GATE_BYTE_W   = 8;        // one byte of enables per gate
    localparam int          LCGIM_SRC_FIELD_W   = 4;        // source select nibble pitch
    localparam logic [1:0]  LCGIM_RESP_OKAY     = 2'b00;
    localparam logic [1:0]  LCGIM_RESP_SLVERR   = 2'b10;

    // one gate's enables: source 4 true at the top, source 1 inverted at the bottom
    typedef struct packed {
        logic s4_true;
        logic s4_inv;
        logic s3_true;
        logic s3_inv;
        logic s2_true;
        logic s2_inv;
        logic s1_true;
        logic s1_inv;
    } lcgim_gate_en_t;

    typedef struct packed {
        logic [3:0] gate_out;     // after polarity
        logic [3:0] gate_raw;     // before polarity
        logic [3:0] source_data;  // selected data sources 4..1
    } lcgim_status_t;

    typedef enum logic [2:0] {
        LCGIM_W_IDLE = 3'b001,
        LCGIM_W_RESP = 3'b010,
        LCGIM_W_HOLD = 3'b100
    } lcgim_wstate_t;
endpackage : lcgim_pkg
`default_nettype wire

// ===== lcgim_matrix_tb_top.sv
// self-checking bench for lcgim_matrix: drives AXI4-Lite and the candidate inputs directly
// assumes the design's own assertions watch the internal gate terms and the source 4 mux; expectations come from shadow copies of the registers
`default_nettype none
module lcgim_matrix_tb_top
    import lcgim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LIMIT = 20000;  // cycles; the full run needs well under a quarter of this

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cands [4];
    logic [3:0]  gate_out;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [15:0] sh_lo = 16'h0, sh_hi = 16'h0, sh_src = 16'h0;
    logic [3:0]  sh_pol = 4'h0;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;

    initial cands = '{8'h00, 8'h00, 8'h00, 8'h00};
    always #25 clk = ~clk;

    lcgim_matrix dut (
        .clk(clk), .rst(rst), .source1_cands(cands[0]), .source2_cands(cands[1]),
        .source3_cands(cands[2]), .source4_cands(cands[3]), .gate_out(gate_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    task automatic test_done();
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // readies sampled at the falling edge, so the handshake edge is the next rising one
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                             input logic [1:0] er = LCGIM_RESP_OKAY);
        logic aw_t, w_t, b_t, done;
        done = 1'b0;
        awaddr <= a; wdata <= d; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            if (b_t) chk("bresp", {30'h0, er}, {30'h0, bresp});
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) begin
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        // let one edge pass with bready low, so a following call never drops and raises it in one step
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er = LCGIM_RESP_OKAY);
        logic ar_t, done;
        done = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            if (rvalid) begin
                d = rdata;
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                done = 1'b1;
            end
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        @(posedge clk);
    endtask : axi_read

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}};
        axi_write(a, d, st);
        case (a)
            LCGIM_OFF_SEL_LOW:  sh_lo = (sh_lo & ~m) | (d[15:0] & m);
            LCGIM_OFF_SEL_HIGH: sh_hi = (sh_hi & ~m) | (d[15:0] & m);
            LCGIM_OFF_POLARITY: if (st[0]) sh_pol = d[3:0];
            default:            sh_src = ((sh_src & ~m) | (d[15:0] & m)) & LCGIM_SOURCE_MASK;
        endcase
    endtask : reg_wr

    function automatic logic [3:0] model();
        logic [3:0] d, g;
        logic [7:0] en;
        d = {cands[3][sh_src[14:12]], cands[2][sh_src[10:8]], cands[1][sh_src[6:4]], cands[0][sh_src[2:0]]};
        for (int i = 0; i < 4; i++) begin
            en = (i < 2) ? sh_lo[8*i +: 8] : sh_hi[8*(i-2) +: 8];
            g[i] = 1'b0;
            for (int s = 0; s < 4; s++) g[i] |= (en[2*s+1] & d[s]) | (en[2*s] & ~d[s]);
        end
        return g ^ sh_pol;
    endfunction : model

    // inputs set at the last edge are sampled at the next one; look half a cycle later
    task automatic gate_chk();
        @(posedge clk);
        @(negedge clk);
        chk("gate_out", {28'h0, model()}, {28'h0, gate_out});
        @(posedge clk);
    endtask : gate_chk

    task automatic t_reset();
        logic [31:0] r;
        axi_read(LCGIM_OFF_SEL_LOW, r);
        chk("sel_low", {16'h0, LCGIM_RST_SEL_LOW}, r);
        axi_read(LCGIM_OFF_SEL_HIGH, r);
        chk("sel_high", {16'h0, LCGIM_RST_SEL_HIGH}, r);
        axi_read(LCGIM_OFF_SOURCE, r);
        chk("source", {16'h0, LCGIM_RST_SOURCE}, r);
        axi_read(LCGIM_OFF_POLARITY, r);
        chk("polarity", {28'h0, LCGIM_RST_POLARITY}, r);
        gate_chk();
    endtask : t_reset

    // one enable bit at a time, all sixteen source patterns on select value zero
    task automatic t_walk();
        logic [31:0] r;
        for (int b = 0; b < 32; b++) begin
            reg_wr(LCGIM_OFF_SEL_LOW, (b < 16) ? 32'h1 << b : 32'h0, 4'h3);
            reg_wr(LCGIM_OFF_SEL_HIGH, (b >= 16) ? 32'h1 << (b - 16) : 32'h0, 4'h3);
            axi_read((b < 16) ? LCGIM_OFF_SEL_LOW : LCGIM_OFF_SEL_HIGH, r);
            chk("sel_readback", 32'h1 << (b % 16), r);
            for (int d = 0; d < 16; d++) begin
                for (int s = 0; s < 4; s++) cands[s] <= {7'h0, d[s]};
                gate_chk();
            end
        end
    endtask : t_walk

    task automatic t_polarity();
        logic [31:0] r;
        reg_wr(LCGIM_OFF_SEL_LOW, 32'h0000_0201, 4'h3);
        reg_wr(LCGIM_OFF_SEL_HIGH, 32'h0000_0000, 4'h3);
        for (int p = 0; p < 16; p++) begin
            reg_wr(LCGIM_OFF_POLARITY, p, 4'h1);
            axi_read(LCGIM_OFF_POLARITY, r);
            chk("polarity", {28'h0, sh_pol}, {28'h0, r[3:0]});
            for (int d = 0; d < 2; d++) begin
                cands[0] <= {7'h0, d[0]};
                gate_chk();
            end
        end
        reg_wr(LCGIM_OFF_POLARITY, 32'h0, 4'h1);
    endtask : t_polarity

    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            reg_wr(LCGIM_OFF_SEL_LOW, 32'h1 << (2*s + 1), 4'h3);
            for (int n = 0; n < 8; n++) begin
                reg_wr(LCGIM_OFF_SOURCE, n << (LCGIM_SRC_FIELD_W * s), 4'h3);
                cands[s] <= 8'h01 << n;
                gate_chk();
                cands[s] <= ~(8'h01 << n);
                gate_chk();
            end
            cands[s] <= 8'h00;
        end
    endtask : t_select

    // byte strobes and unimplemented source bits
    task automatic t_strobe();
        logic [31:0] r;
        reg_wr(LCGIM_OFF_SEL_LOW, 32'h0, 4'h3);
        reg_wr(LCGIM_OFF_SEL_LOW, 32'h0000_A5C3, 4'h1);
        axi_read(LCGIM_OFF_SEL_LOW, r);
        chk("sel_low_strb0", {16'h0, sh_lo}, r);
        reg_wr(LCGIM_OFF_SEL_LOW, 32'h0000_A5C3, 4'h2);
        axi_read(LCGIM_OFF_SEL_LOW, r);
        chk("sel_low_strb1", 32'h0000_A5C3, r);
        reg_wr(LCGIM_OFF_SOURCE, 32'hFFFF_FFFF, 4'hF);
        axi_read(LCGIM_OFF_SOURCE, r);
        chk("source_mask", {16'h0, LCGIM_SOURCE_MASK}, r);
        // unmapped offset: write ignored and refused, read gives zero and refusal
        axi_write(4'h2, 32'hFFFF_FFFF, 4'h3, LCGIM_RESP_SLVERR);
        axi_read(LCGIM_OFF_SEL_LOW, r);
        chk("sel_low_unmapped", {16'h0, sh_lo}, r);
        axi_read(4'h2, r, LCGIM_RESP_SLVERR);
        chk("unmapped_read", 32'h0, r);
        gate_chk();
    endtask : t_strobe

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_walk();
        t_polarity();
        t_select();
        t_strobe();
        test_done();
    end
endmodule : lcgim_matrix_tb_top
`default_nettype wire
